/* aarc_cal.sv */
// Notes on behaviour
// - gain-1 offset: 15-bit two's complement, low bits
// - offset step is a quarter result LSB
// - 0x3FFF adds 4095.75, 0x0001 adds 0.25
// - 0x7FFF subtracts 0.25, 0x4000 subtracts 4096
// - separate same-format offset for gain 1.5
// - gain coefficient only for gain-1 non-excluded channels
// - gain: unsigned, integer bit 14, fraction bits 13:0
// - gain 0x4000 is unity and reset value
// - 0x2000 halves, 0x7FFF nearly doubles
// - 0x4001 and 0x3FFF are smallest steps
// - 0x0001 is smallest nonzero multiplier
// - gain zero forces result 0x8000
//
// The Wishbone interface to the registers was left to the implementer.
`include "aarc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module aarc_cal (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,

  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,

  // raw conversions in
  input wire logic sample_vld,
  input wire aarc_pkg::aarc_sample_t sample,

  // corrected conversions out
  output logic result_vld,
  output aarc_pkg::aarc_result_t result
);

  ////////////////////////////////////////////////////////////////
  // decode, shared by read and write paths

  function automatic aarc_pkg::aarc_reg_t aarc_decode(
    input logic [15:0] adr
  );
    aarc_pkg::aarc_reg_t r;
    r = aarc_pkg::AARC_REG_NONE;

    // exact match only, so no register aliases elsewhere
    case (adr)

      `AARC_GAIN1_OFF: begin
        r = aarc_pkg::AARC_REG_GAIN1;
      end

      `AARC_OFFS1_OFF: begin
        r = aarc_pkg::AARC_REG_OFFS1;
      end

      `AARC_OFFS15_OFF: begin
        r = aarc_pkg::AARC_REG_OFFS15;
      end

      `AARC_STATUS_OFF: begin
        r = aarc_pkg::AARC_REG_STATUS;
      end

      default: begin
        r = aarc_pkg::AARC_REG_NONE;
      end

    endcase

    return r;
  endfunction

  // byte-lane merge; only lanes 0 and 1 reach the 15-bit fields
  function automatic logic [14:0] aarc_merge(
    input logic [14:0] old,
    input logic [31:0] dat,
    input logic [3:0] sel
  );
    logic [15:0] w;

    w = {1'b0, old};

    for (int i = 0; i < 2; i++) begin
      if (sel[i]) begin
        w[i*8 +: 8] = dat[i*8 +: 8];
      end
    end

    // bit 15 of lane 1 has no field behind it and falls away
    return w[14:0];
  endfunction

  // round to nearest and clamp; the msb reports a clamp
  function automatic logic [16:0] aarc_scale(
    input logic signed [19:0] s,
    input logic [14:0] g
  );
    logic signed [35:0] s_ext;
    logic signed [35:0] g_ext;
    logic signed [35:0] p;
    logic signed [35:0] r;

    // widen both factors first so the product cannot wrap
    s_ext = {{16{s[19]}}, s};
    g_ext = {21'h000000, g};

    p = s_ext * g_ext;

    // half a result step before the shift, so halves round up
    r = (p + `AARC_ROUND) >>> `AARC_SHIFT;

    // clamp to the result word and report it
    if (r < 36'sh000000000) begin
      return {1'b1, `AARC_RES_MIN};
    end else if (r > $signed({20'h00000, `AARC_RES_MAX})) begin
      return {1'b1, `AARC_RES_MAX};
    end
    return {1'b0, r[15:0]};
  endfunction

  ////////////////////////////////////////////////////////////////
  // state

  aarc_pkg::aarc_state_t st;
  aarc_pkg::aarc_state_t next_st;

  // bus side
  aarc_pkg::aarc_reg_t hit;
  logic req;
  logic wr_cycle;
  logic [1:0] lane_we;

  // datapath side
  logic [14:0] sel_offs;
  logic [14:0] sel_gain;
  logic [16:0] scaled;

  assign req = wb_cyc_i & wb_stb_i;
  assign hit = aarc_decode(wb_adr_i);

  // a write commits only on the edge at which the master sees ack
  assign wr_cycle = req & st.ack & wb_we_i;

  ////////////////////////////////////////////////////////////////
  // byte-lane write strobes; lanes 2 and 3 have no field behind them

  generate
    for (genvar i = 0; i < 2; i++) begin : g_lane
      assign lane_we[i] = wr_cycle & wb_sel_i[i];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // coefficient selection for the incoming conversion

  always_comb begin
    sel_offs = `AARC_OFFS_NONE;
    sel_gain = `AARC_GAIN_UNITY;

    // the excluded flag keeps the amplifier and sensor channels raw
    case (sample.pga)

      aarc_pkg::AARC_PGA_GAIN1: begin
        if (!sample.excluded) begin
          sel_offs = st.aux_gain1_offset_coeff;
          sel_gain = st.aux_gain1_gain_coeff;
        end
      end

      aarc_pkg::AARC_PGA_GAIN1P5: begin
        // no gain register for 1.5 here, so unity multiplier
        if (!sample.excluded) begin
          sel_offs = st.aux_gain1p5_offset_coeff;
        end
      end

      default: begin
        sel_offs = `AARC_OFFS_NONE;
        sel_gain = `AARC_GAIN_UNITY;
      end
    endcase
  end

  // second stage: multiply with 14 fraction bits, plus 2 offset bits
  assign scaled = aarc_scale(st.s1_sum, st.s1_gain);

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;

    // bus: ack one cycle after the request, dropped the cycle after;
    // a strobe held through the ack cycle is not taken on that edge, but is taken again one cycle later

    next_st.ack = req & ~st.ack;

    if (req & ~st.ack) begin
      // unmapped and reserved bits read as zero
      next_st.rdat = 32'h00000000;

      case (hit)

        aarc_pkg::AARC_REG_GAIN1: begin
          next_st.rdat[14:0] = st.aux_gain1_gain_coeff;
        end

        aarc_pkg::AARC_REG_OFFS1: begin
          next_st.rdat[14:0] = st.aux_gain1_offset_coeff;
        end

        aarc_pkg::AARC_REG_OFFS15: begin
          next_st.rdat[14:0] = st.aux_gain1p5_offset_coeff;
        end

        // last result, so software can see a clamp or an illegal gain
        aarc_pkg::AARC_REG_STATUS: begin
          next_st.rdat[15:0] = st.out.data;
          next_st.rdat[`AARC_STAT_SAT_BIT] = st.out.sat;
          next_st.rdat[`AARC_STAT_ILL_BIT] = st.last_illegal;
        end

        default: begin
          next_st.rdat = 32'h00000000;
        end
      endcase
    end

    // writes land on the edge where ack is already high;
    // the status word has no write path, so writes to it vanish

    if (wr_cycle) begin

      case (hit)

        aarc_pkg::AARC_REG_GAIN1: begin
          // zero is accepted but flagged in the datapath
          next_st.aux_gain1_gain_coeff =
            aarc_merge(st.aux_gain1_gain_coeff, wb_dat_i, {2'b00, lane_we});
        end

        aarc_pkg::AARC_REG_OFFS1: begin
          next_st.aux_gain1_offset_coeff =
            aarc_merge(st.aux_gain1_offset_coeff, wb_dat_i, {2'b00, lane_we});
        end

        aarc_pkg::AARC_REG_OFFS15: begin
          next_st.aux_gain1p5_offset_coeff =
            aarc_merge(st.aux_gain1p5_offset_coeff, wb_dat_i, {2'b00, lane_we});
        end

        default: begin
          next_st.rdat = st.rdat;
        end
      endcase
    end

    // first stage: raw in quarter steps plus signed offset
    next_st.s1_vld = sample_vld;

    if (sample_vld) begin
      // 18 bits of quarters, a sign and a carry: the sum never wraps
      next_st.s1_sum = $signed({2'b00, sample.raw, 2'b00}) +
        $signed({{5{sel_offs[`AARC_COEF_MSB]}}, sel_offs});

      // gain travels with its sample, so a write mid-flight cannot split it
      next_st.s1_gain = sel_gain;
      next_st.s1_illegal = (sel_gain == `AARC_GAIN_ILLEGAL);
    end

    // second stage: scale, round, clamp
    next_st.out_vld = st.s1_vld;

    if (st.s1_vld) begin

      if (st.s1_illegal) begin
        next_st.out.data = `AARC_ILLEGAL_RESULT;
        next_st.out.sat = 1'b0;
      end else begin
        next_st.out.data = scaled[15:0];
        next_st.out.sat = scaled[16];
      end

      next_st.last_illegal = st.s1_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin

      // coefficients
      st.aux_gain1_gain_coeff <= `AARC_GAIN1_RST;
      st.aux_gain1_offset_coeff <= `AARC_OFFS1_RST;
      st.aux_gain1p5_offset_coeff <= `AARC_OFFS15_RST;

      // bus answer
      st.ack <= 1'b0;
      st.rdat <= 32'h00000000;

      // first stage
      st.s1_vld <= 1'b0;
      st.s1_sum <= 20'sh00000;
      st.s1_gain <= `AARC_GAIN_UNITY;
      st.s1_illegal <= 1'b0;

      // second stage and status
      st.out_vld <= 1'b0;
      st.out <= 17'h00000;
      st.last_illegal <= 1'b0;

    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs, all straight from flops

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdat;
  assign result_vld = st.out_vld;
  assign result = st.out;

endmodule

`default_nettype wire

/* aarc_cal_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module aarc_cal_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // sample path
  input wire logic sample_vld,
  input wire aarc_pkg::aarc_sample_t sample,
  input wire logic result_vld,
  input wire aarc_pkg::aarc_result_t result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_out;
    ##2 result_vld;
  endsequence
  a_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  a_res_lat: assert property (sample_vld |-> s_out) else $error("result late");
  a_res_cause: assert property (result_vld |-> $past(sample_vld, 2)) else $error("stray result");
  a_pass_thru: assert property (sample_vld && (sample.excluded || sample.pga == aarc_pkg::AARC_PGA_OTHER)
    |-> ##2 result.data == $past(sample.raw, 2)) else $error("bypass altered");
  a_sat_range: assert property (result_vld && result.sat |-> result.data inside {16'h0000, 16'hFFFF})
    else $error("sat not at limit");
  a_rsv_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i != 16'h22D0 |-> wb_dat_o[31:15] == 17'h00000)
    else $error("upper bits set");
  a_unmapped_rd: assert property (wb_ack_o && !wb_we_i && !(wb_adr_i inside {16'h2240, 16'h2244, 16'h22CC,
    16'h22D0}) |-> wb_dat_o == 32'h00000000) else $error("unmapped data");
endmodule
bind aarc_cal aarc_cal_checker i_aarc_cal_checker (.mclk(mclk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sample_vld(sample_vld), .sample(sample), .result_vld(result_vld), .result(result));
`default_nettype wire

/* aarc_cal_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module aarc_cal_tb_top;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic we = 1'b0;
  logic sample_vld = 1'b0;
  logic ack, result_vld;
  logic [15:0] adr = 16'h0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat, q;
  aarc_pkg::aarc_sample_t sample = '0;
  aarc_pkg::aarc_result_t result;
  int n_mismatch = 0;
  int num_checks = 0;
  aarc_cal i_aarc_cal (.mclk(mclk), .resetn(resetn), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sample_vld(sample_vld), .sample(sample), .result_vld(result_vld), .result(result));
  initial begin
    forever #20 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // quarter-step offset, then 1.14 gain, half rounds up
  function automatic logic [16:0] exp_res(input logic [15:0] r, input logic [14:0] o, input logic [14:0] g);
    longint s;
    s = ((longint'(r) * 4 + longint'($signed(o))) * longint'(g) + 32768) >>> 16;
    if (g == 15'h0000) return 17'h10000;
    if (s < 0) return 17'h00001;
    if (s > 65535) return 17'h1FFFF;
    return {s[15:0], 1'b0};
  endfunction
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      give_verdict();
    end
    q = rdat;
    req <= 1'b0;
  endtask
  task automatic send(input logic [15:0] r, input aarc_pkg::aarc_pga_t p, input logic x, input logic [16:0] e);
    @(posedge mclk);
    sample_vld <= 1'b1;
    sample <= '{raw: r, pga: p, excluded: x};
    @(posedge mclk);
    sample_vld <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    chk({14'h0000, result_vld, result}, {14'h0000, 1'b1, e});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    wb(1'b0, 16'h2240, 32'h0);
    chk(q, 32'h4000);
    wb(1'b0, 16'h22CC, 32'h0);
    chk(q, 32'h0);
    wb(1'b1, 16'h2244, 32'hFFFFFFFF);
    wb(1'b0, 16'h2244, 32'h0);
    chk(q, 32'h7FFF);
    wb(1'b1, 16'h2248, 32'h1234);
    wb(1'b0, 16'h2248, 32'h0);
    chk(q, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_offset;
    logic [14:0] ofs [5] = '{15'h3FFF, 15'h0001, 15'h0000, 15'h7FFF, 15'h4000};
    logic [15:0] raw [5] = '{16'h0100, 16'h8000, 16'h8000, 16'h8000, 16'h4000};
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 16'h2244, {17'h0, ofs[i]});
      send(raw[i], aarc_pkg::AARC_PGA_GAIN1, 1'b0, exp_res(raw[i], ofs[i], 15'h4000));
    end
    $display("t_offset done");
  endtask
  task automatic t_gain;
    logic [14:0] gn [6] = '{15'h2000, 15'h7FFF, 15'h4001, 15'h3FFF, 15'h0001, 15'h0000};
    wb(1'b1, 16'h2244, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, 16'h2240, {17'h0, gn[i]});
      send(16'h8001, aarc_pkg::AARC_PGA_GAIN1, 1'b0, exp_res(16'h8001, 15'h0, gn[i]));
    end
    wb(1'b0, 16'h22D0, 32'h0);
    chk(q, 32'h00028000);
    // gain is left at zero so any leak into other paths shows
    send(16'h1234, aarc_pkg::AARC_PGA_GAIN1, 1'b1, 17'h02468);
    send(16'h1234, aarc_pkg::AARC_PGA_OTHER, 1'b0, 17'h02468);
    wb(1'b1, 16'h22CC, 32'h0008);
    send(16'h1000, aarc_pkg::AARC_PGA_GAIN1P5, 1'b0, 17'h02004);
    wb(1'b0, 16'h22D0, 32'h0);
    chk(q, 32'h00001002);
    $display("t_gain done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_offset();
    t_gain();
    @(posedge mclk);
    resetn <= 1'b0;
    @(posedge mclk);
    resetn <= 1'b1;
    wb(1'b0, 16'h2240, 32'h0);
    chk(q, 32'h4000);
    $display("t_rereset done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* aarc_map.svh */
`ifndef AARC_MAP_SVH
`define AARC_MAP_SVH

// register byte offsets on the bus
`define AARC_GAIN1_OFF 16'h2240
`define AARC_OFFS1_OFF 16'h2244
`define AARC_OFFS15_OFF 16'h22CC
`define AARC_STATUS_OFF 16'h22D0

// reset values of the coefficient fields
`define AARC_GAIN1_RST 15'h4000
`define AARC_OFFS1_RST 15'h0000
`define AARC_OFFS15_RST 15'h0000

// field layout
`define AARC_COEF_MSB 14
`define AARC_COEF_W 15
`define AARC_RES_W 16
`define AARC_STAT_SAT_BIT 16
`define AARC_STAT_ILL_BIT 17

// arithmetic constants
`define AARC_GAIN_UNITY 15'h4000
`define AARC_GAIN_ILLEGAL 15'h0000
`define AARC_OFFS_NONE 15'h0000
`define AARC_ILLEGAL_RESULT 16'h8000
`define AARC_RES_MAX 16'hFFFF
`define AARC_RES_MIN 16'h0000
`define AARC_ROUND 36'sh000008000
`define AARC_SHIFT 16

`endif

/* aarc_pkg.sv */
package aarc_pkg;

  // amplifier gain used for a conversion
  typedef enum logic [2:0] {
    AARC_PGA_GAIN1 = 3'h1,
    AARC_PGA_GAIN1P5 = 3'h2,
    AARC_PGA_OTHER = 3'h4
  } aarc_pga_t;

  // register decode, one-hot
  typedef enum logic [4:0] {
    AARC_REG_NONE = 5'h01,
    AARC_REG_GAIN1 = 5'h02,
    AARC_REG_OFFS1 = 5'h04,
    AARC_REG_OFFS15 = 5'h08,
    AARC_REG_STATUS = 5'h10
  } aarc_reg_t;

  // raw conversion arriving from the converter
  typedef struct packed {
    logic [15:0] raw;
    aarc_pga_t pga;
    logic excluded;
  } aarc_sample_t;

  // corrected converted_result_word
  typedef struct packed {
    logic [15:0] data;
    logic sat;
  } aarc_result_t;

  typedef struct packed {
    logic [14:0] aux_gain1_gain_coeff;
    logic [14:0] aux_gain1_offset_coeff;
    logic [14:0] aux_gain1p5_offset_coeff;
    logic ack;
    logic [31:0] rdat;
    logic s1_vld;
    logic signed [19:0] s1_sum;
    logic [14:0] s1_gain;
    logic s1_illegal;
    logic out_vld;
    aarc_result_t out;
    logic last_illegal;
  } aarc_state_t;

endpackage
